// ---- hdl/acr_adc_ctrl.sv ----
// acr_adc_ctrl: digital control of a 10-bit converter: result bytes,
// auto trigger selection, comparator input mux and pin input disable.
// assumes the analog core pulses conv_done_i with conv_data_i valid,
// and that trigger flags arrive synchronous to clk_sys_i.
`timescale 1ns/10ps
module acr_adc_ctrl
  import acr_pkg::*;
#(
  parameter int RES_W = 10,
  parameter int PIN_N = 8
)(
  input  wire logic               clk_sys_i,
  input  wire logic               reset_i,
  input  wire logic               ce_i,
  // register port
  input  wire logic [7:0]         addr_i,
  input  wire logic [7:0]         wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  output logic      [7:0]         rd_data_o,
  // analog core
  input  wire logic               conv_done_i,
  input  wire logic [RES_W-1:0]   conv_data_i,
  output logic                    conv_start_o,
  output logic                    conv_enable_o,
  // trigger flags, indexed by source code, bit 0 unused
  input  wire logic [7:0]         trig_flags_i,
  // comparator negative input: 1 = converter mux, 0 = dedicated pin
  output logic                    cmp_neg_from_mux_o,
  // pins
  input  wire logic [PIN_N-1:0]   pin_digital_i,
  output logic [PIN_N-1:0]        pin_digital_o,
  output logic [PIN_N-1:0]        pin_input_disable_o,
  output logic                    irq_o
);
  import acr_pkg::*;

  // ==========================================================
  // elaboration checks
  if (RES_W != 10) begin : g_bad_res
    $error("acr_adc_ctrl: result width must be 10");
  end
  if (PIN_N != 8) begin : g_bad_pins
    $error("acr_adc_ctrl: pin count must be 8");
  end

  // ==========================================================
  // presentation of one result byte, hi selects the high byte
  function automatic logic [7:0] acr_present(input logic left,
                                             input logic [9:0] res,
                                             input logic hi);
    logic [7:0] b;
    b = 8'h00;
    if (left)
      b = hi ? res[9:2] : {res[1:0], 6'h00};
    else
      b = hi ? {6'h00, res[9:8]} : res[7:0];
    return b;
  endfunction

  // ==========================================================
  // state
  logic [7:0] ctl_a_r;
  logic [7:0] ctl_b_r;
  logic [7:0] mux_r;
  logic [7:0] pin_dis_r;
  logic [7:0] irq_stat_r;
  logic [7:0] irq_mask_r;
  logic [9:0] result_r;
  logic       lock_r;
  logic       busy_r;
  logic       trig_prev_r;
  logic       done_flag_r;

  logic wr_a, wr_b, wr_m, wr_d, wr_mask;
  logic rd_lo, rd_hi, rd_stat;
  logic enable, auto_on, left;
  logic trig_sig, trig_edge, sw_start, free_restart, start_req, start_ok;
  acr_trg_src_t trg_sel;

  assign wr_a    = wr_i && addr_i == ACR_OFS_CTL_A;
  assign wr_b    = wr_i && addr_i == ACR_OFS_CTL_B;
  assign wr_m    = wr_i && addr_i == ACR_OFS_MUX;
  assign wr_d    = wr_i && addr_i == ACR_OFS_PIN_DIS;
  assign wr_mask = wr_i && addr_i == ACR_OFS_IRQ_MASK;
  assign rd_lo   = rd_i && addr_i == ACR_OFS_RES_LO;
  assign rd_hi   = rd_i && addr_i == ACR_OFS_RES_HI;
  assign rd_stat = rd_i && addr_i == ACR_OFS_IRQ_STAT;

  assign enable  = ctl_a_r[ACR_A_ENABLE];
  assign auto_on = ctl_a_r[ACR_A_AUTO];
  assign left    = mux_r[ACR_M_LEFT];
  assign trg_sel = acr_trg_src_t'(ctl_b_r[2:0]);

  // ==========================================================
  // trigger: the selected flag, forced low when auto is off or the
  // source is free running, so neither can ever make an edge
  always_comb
  begin
    trig_sig = 1'b0;
    case (trg_sel)
      ACR_TRG_FREE: trig_sig = 1'b0;
      default:      trig_sig = auto_on && trig_flags_i[trg_sel];
    endcase
  end

  // a change of selection onto a set flag from a clear one is seen as an edge just like a flag rising
  assign trig_edge    = trig_sig && !trig_prev_r;
  assign sw_start     = wr_a && wdata_i[ACR_A_START] && wdata_i[ACR_A_ENABLE];
  assign free_restart = auto_on && trg_sel == ACR_TRG_FREE && conv_done_i;
  assign start_ok     = enable && (!busy_r || conv_done_i);
  assign start_req    = start_ok && (trig_edge || sw_start || free_restart);

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      trig_prev_r <= 1'b0;
    else if (ce_i)
      trig_prev_r <= trig_sig;
  end

  // ==========================================================
  // conversion start pulse and busy tracking; disabling aborts
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      conv_start_o <= 1'b0;
      busy_r       <= 1'b0;
    end
    else if (ce_i)
    begin
      conv_start_o <= start_req;
      if (!enable)
        busy_r <= 1'b0;
      else if (start_req)
        busy_r <= 1'b1;
      else if (conv_done_i)
        busy_r <= 1'b0;
    end
  end

  // ==========================================================
  // result capture; a read of the low byte freezes the result so the
  // two bytes come from one conversion, unless one completes in that read cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      result_r <= ACR_RST_RES;
    else if (ce_i && conv_done_i && !lock_r)
      result_r <= conv_data_i;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      lock_r <= 1'b0;
    else if (ce_i)
    begin
      if (rd_hi)
        lock_r <= 1'b0;
      else if (rd_lo)
        lock_r <= 1'b1;
    end
  end

  // ==========================================================
  // done flag: set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      done_flag_r <= 1'b0;
    else if (ce_i)
    begin
      if (conv_done_i)
        done_flag_r <= 1'b1;
      else if (wr_a && wdata_i[ACR_A_DONE])
        done_flag_r <= 1'b0;
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      ctl_a_r    <= ACR_RST_BYTE;
      ctl_b_r    <= ACR_RST_BYTE;
      mux_r      <= ACR_RST_BYTE;
      pin_dis_r  <= ACR_RST_BYTE;
      irq_mask_r <= ACR_RST_BYTE;
    end
    else if (ce_i)
    begin
      if (wr_a)
      begin
        ctl_a_r[ACR_A_ENABLE] <= wdata_i[ACR_A_ENABLE];
        ctl_a_r[ACR_A_AUTO]   <= wdata_i[ACR_A_AUTO];
        ctl_a_r[3:0]          <= wdata_i[3:0] & ACR_A_KEEP_MASK[3:0];
      end
      if (wr_b)
        ctl_b_r <= wdata_i & ACR_B_MASK;
      if (wr_m)
        mux_r <= wdata_i & ACR_M_MASK;
      if (wr_d)
        pin_dis_r <= wdata_i;
      if (wr_mask)
        irq_mask_r <= wdata_i & ACR_I_MASK;
    end
  end

  // ==========================================================
  // interrupt status: sticky, cleared by a read; a new event in the
  // clearing cycle survives
  logic [7:0] irq_events;
  assign irq_events = {5'h00,
                       trig_edge && !start_ok,
                       trig_edge,
                       conv_done_i};

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      irq_stat_r <= ACR_RST_BYTE;
    else if (ce_i)
      irq_stat_r <= (rd_stat ? 8'h00 : irq_stat_r) | irq_events;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      irq_o <= 1'b0;
    else if (ce_i)
      irq_o <= |(irq_stat_r & irq_mask_r);
  end

  // ==========================================================
  // read data, one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      rd_data_o <= 8'h00;
    else if (ce_i)
    begin
      rd_data_o <= 8'h00;
      if (rd_i)
      begin
        case (addr_i)
          ACR_OFS_RES_LO:   rd_data_o <= acr_present(left, result_r, 1'b0);
          ACR_OFS_RES_HI:   rd_data_o <= acr_present(left, result_r, 1'b1);
          ACR_OFS_CTL_A:    rd_data_o <= {enable, busy_r, auto_on,
                                          done_flag_r, ctl_a_r[3:0]};
          ACR_OFS_CTL_B:    rd_data_o <= ctl_b_r;
          ACR_OFS_MUX:      rd_data_o <= mux_r;
          ACR_OFS_PIN_DIS:  rd_data_o <= pin_dis_r;
          ACR_OFS_IRQ_STAT: rd_data_o <= irq_stat_r;
          ACR_OFS_IRQ_MASK: rd_data_o <= irq_mask_r;
          default:          rd_data_o <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // pin side outputs; the gated port input avoids a floating analog
  // level toggling the digital path
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      pin_input_disable_o <= '0;
      pin_digital_o       <= '0;
      cmp_neg_from_mux_o  <= 1'b0;
      conv_enable_o       <= 1'b0;
    end
    else if (ce_i)
    begin
      pin_input_disable_o <= pin_dis_r;
      pin_digital_o       <= pin_digital_i & ~pin_dis_r;
      // mux only while the converter is off, else the pin
      cmp_neg_from_mux_o  <= ctl_b_r[ACR_B_CMP_MUX] && !enable;
      conv_enable_o       <= enable;
    end
  end

  // ==========================================================
  // assertions
  property p_right_hi;
    @(posedge clk_sys_i) disable iff (reset_i)
    (ce_i && rd_hi && !left) |=> rd_data_o == {6'h00, $past(result_r[9:8])};
  endproperty
  a_right_hi: assert property (p_right_hi) else $error("right high byte wrong");

  property p_left_lo;
    @(posedge clk_sys_i) disable iff (reset_i)
    (ce_i && rd_lo && left) |=> rd_data_o == {$past(result_r[1:0]), 6'h00};
  endproperty
  a_left_lo: assert property (p_left_lo) else $error("left low byte wrong");

  property p_left_hi;
    @(posedge clk_sys_i) disable iff (reset_i)
    (ce_i && rd_hi && left) |=> rd_data_o == $past(result_r[9:2]);
  endproperty
  a_left_hi: assert property (p_left_hi) else $error("left high byte wrong");

  property p_cmp_mux;
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i |=> cmp_neg_from_mux_o == ($past(ctl_b_r[ACR_B_CMP_MUX]) && !$past(enable));
  endproperty
  a_cmp_mux: assert property (p_cmp_mux) else $error("comparator mux wrong");

  property p_no_auto;
    @(posedge clk_sys_i) disable iff (reset_i)
    (ce_i && !auto_on && !sw_start) |=> !conv_start_o;
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("start without auto");

  property p_edge_start;
    @(posedge clk_sys_i) disable iff (reset_i)
    (ce_i && trig_sig && !trig_prev_r && enable && !busy_r) |=> conv_start_o;
  endproperty
  a_edge_start: assert property (p_edge_start) else $error("edge lost");

  // free running selection: no start unless software or a completion
  property p_free_none;
    @(posedge clk_sys_i) disable iff (reset_i)
    (ce_i && trg_sel == ACR_TRG_FREE && !sw_start && !conv_done_i)
      |=> !conv_start_o;
  endproperty
  a_free_none: assert property (p_free_none) else $error("free run edge");

  property p_pin_gate;
    @(posedge clk_sys_i) disable iff (reset_i)
    ce_i ##1 ce_i |-> (pin_digital_o & pin_input_disable_o) == '0;
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("disabled pin reads one");

  property p_lock_hold;
    @(posedge clk_sys_i) disable iff (reset_i)
    (ce_i && lock_r && !rd_hi) |=> $stable(result_r);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("locked result moved");

  property p_done_set;
    @(posedge clk_sys_i) disable iff (reset_i)
    (ce_i && conv_done_i) |=> done_flag_r;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_ctlb_zero;
    @(posedge clk_sys_i) disable iff (reset_i)
    (ce_i && rd_i && addr_i == ACR_OFS_CTL_B) |=> (rd_data_o & ~ACR_B_MASK) == 8'h00;
  endproperty
  a_ctlb_zero: assert property (p_ctlb_zero) else $error("control B spare bits");

  c_trig_start: cover property (@(posedge clk_sys_i) disable iff (reset_i)
    trig_edge && enable ##1 conv_start_o);
  c_locked_done: cover property (@(posedge clk_sys_i) disable iff (reset_i)
    lock_r && conv_done_i);
  c_irq: cover property (@(posedge clk_sys_i) disable iff (reset_i)
    rd_stat ##1 irq_o);

endmodule // acr_adc_ctrl

// ---- hdl/acr_pkg.sv ----
// acr_pkg: register map, field positions and reset values of the
// converter control block.
// assumes an 8-bit register port with byte offsets as printed.
package acr_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] ACR_OFS_RES_LO   = 8'h78;
  localparam logic [7:0] ACR_OFS_RES_HI   = 8'h79;
  localparam logic [7:0] ACR_OFS_CTL_A    = 8'h7A;
  localparam logic [7:0] ACR_OFS_CTL_B    = 8'h7B;
  localparam logic [7:0] ACR_OFS_MUX      = 8'h7C;
  localparam logic [7:0] ACR_OFS_PIN_DIS  = 8'h7E;
  localparam logic [7:0] ACR_OFS_IRQ_STAT = 8'h70;
  localparam logic [7:0] ACR_OFS_IRQ_MASK = 8'h71;

  // ==========================================================
  // control register A fields
  localparam int ACR_A_ENABLE = 7;
  localparam int ACR_A_START  = 6;
  localparam int ACR_A_AUTO   = 5;
  localparam int ACR_A_DONE   = 4;
  localparam logic [7:0] ACR_A_KEEP_MASK = 8'h0F; // plain r/w low bits

  // control register B fields
  localparam int ACR_B_CMP_MUX = 6;
  localparam logic [7:0] ACR_B_MASK = 8'h47;      // implemented bits

  // mux register fields
  localparam int ACR_M_LEFT = 5;
  localparam logic [7:0] ACR_M_MASK = 8'hEF;      // bit 4 unused

  // interrupt status bits
  localparam int ACR_I_DONE = 0;
  localparam int ACR_I_TRIG = 1;
  localparam int ACR_I_MISS = 2;
  localparam logic [7:0] ACR_I_MASK = 8'h07;

  // ==========================================================
  // reset values
  localparam logic [7:0] ACR_RST_BYTE = 8'h00;
  localparam logic [9:0] ACR_RST_RES  = 10'h000;

  // trigger source codes
  typedef enum logic [2:0] {
    ACR_TRG_FREE   = 3'b000,
    ACR_TRG_CMP    = 3'b001,
    ACR_TRG_EXT0   = 3'b010,
    ACR_TRG_T0_CMA = 3'b011,
    ACR_TRG_T0_OVF = 3'b100,
    ACR_TRG_T1_CMB = 3'b101,
    ACR_TRG_T1_OVF = 3'b110,
    ACR_TRG_T1_CAP = 3'b111
  } acr_trg_src_t;

endpackage

// ---- dv/test_acr_adc_ctrl.sv ----
// test_acr_adc_ctrl: self-checking bench for the converter control block.
// assumes acr_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/10ps
module test_acr_adc_ctrl;
  import acr_pkg::*;

  // ==========================================================
  // stimulus and observed signals
  logic       clk_sys_i     = 1'b0;
  logic       reset_i       = 1'b1;
  logic       ce_i          = 1'b1;
  logic [7:0] addr_i        = 8'h00;
  logic [7:0] wdata_i       = 8'h00;
  logic       wr_i          = 1'b0;
  logic       rd_i          = 1'b0;
  logic       conv_done_i   = 1'b0;
  logic [9:0] conv_data_i   = 10'h000;
  logic [7:0] trig_flags_i  = 8'h00;
  logic [7:0] pin_digital_i = 8'h00;
  logic [7:0] rd_data_o;
  logic       conv_start_o;
  logic       conv_enable_o;
  logic       cmp_neg_from_mux_o;
  logic [7:0] pin_digital_o;
  logic [7:0] pin_input_disable_o;
  logic       irq_o;
  int         n_fail        = 0;
  int         check_count   = 0;
  logic [7:0] n_start       = 8'h00;
  logic [7:0] exp_start;

  // 40 MHz system clock
  always #12.5 clk_sys_i = ~clk_sys_i;

  acr_adc_ctrl acr_adc_ctrl_i (
    .clk_sys_i          (clk_sys_i),
    .reset_i            (reset_i),
    .ce_i               (ce_i),
    .addr_i             (addr_i),
    .wdata_i            (wdata_i),
    .wr_i               (wr_i),
    .rd_i               (rd_i),
    .rd_data_o          (rd_data_o),
    .conv_done_i        (conv_done_i),
    .conv_data_i        (conv_data_i),
    .conv_start_o       (conv_start_o),
    .conv_enable_o      (conv_enable_o),
    .trig_flags_i       (trig_flags_i),
    .cmp_neg_from_mux_o (cmp_neg_from_mux_o),
    .pin_digital_i      (pin_digital_i),
    .pin_digital_o      (pin_digital_o),
    .pin_input_disable_o(pin_input_disable_o),
    .irq_o              (irq_o)
  );

  // count start pulses; they stand one cycle, so each edge sees one
  always @(posedge clk_sys_i)
  begin
    if (conv_start_o === 1'b1)
      n_start <= n_start + 8'h01;
  end

  // ==========================================================
  // bus and compare tasks
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one-cycle write; the leading edge keeps strobes from toggling twice
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] e, input string nm);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
    #1;
    chk(nm, e, rd_data_o & m);
  endtask

  task automatic done(input logic [9:0] d);
    @(posedge clk_sys_i);
    conv_done_i <= 1'b1;
    conv_data_i <= d;
    @(posedge clk_sys_i);
    conv_done_i <= 1'b0;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic end_of_test;
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    n_fail++;
    end_of_test;
  end

  // ==========================================================
  // test sequence
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    // reset values and unmapped space
    rd_chk(ACR_OFS_RES_LO, 8'hFF, 8'h00, "res_lo rst");
    rd_chk(ACR_OFS_RES_HI, 8'hFF, 8'h00, "res_hi rst");
    rd_chk(ACR_OFS_CTL_B, 8'hFF, 8'h00, "ctl_b rst");
    rd_chk(ACR_OFS_PIN_DIS, 8'hFF, 8'h00, "pin_dis rst");
    wr(8'h55, 8'hFF);
    rd_chk(8'h55, 8'hFF, 8'h00, "unmapped");
    wr(ACR_OFS_CTL_B, 8'hFF);
    rd_chk(ACR_OFS_CTL_B, 8'hFF, 8'h47, "ctl_b bits");
    wr(ACR_OFS_CTL_B, 8'h00);
    // pin input disable gates the port input
    pin_digital_i <= 8'hFF;
    wr(ACR_OFS_PIN_DIS, 8'hA5);
    wait_n(2);
    chk("pin_dis_o", 8'hA5, pin_input_disable_o);
    chk("pin_dig_o", 8'h5A, pin_digital_o);
    rd_chk(ACR_OFS_PIN_DIS, 8'hFF, 8'hA5, "pin_dis rd");
    // a write while the clock enable is low must be lost
    @(posedge clk_sys_i);
    ce_i <= 1'b0;
    wr(ACR_OFS_PIN_DIS, 8'h00);
    ce_i <= 1'b1;
    rd_chk(ACR_OFS_PIN_DIS, 8'hFF, 8'hA5, "ce frozen");
    // comparator negative input source, converter off first
    wr(ACR_OFS_CTL_B, 8'h40);
    wait_n(2);
    chk("cmp mux off", 8'h01, {7'h0, cmp_neg_from_mux_o});
    wr(ACR_OFS_CTL_B, 8'h00);
    wait_n(2);
    chk("cmp pin", 8'h00, {7'h0, cmp_neg_from_mux_o});
    wr(ACR_OFS_CTL_B, 8'h40);
    wr(ACR_OFS_CTL_A, 8'h80);
    wait_n(2);
    chk("conv_en", 8'h01, {7'h0, conv_enable_o});
    chk("cmp mux on", 8'h00, {7'h0, cmp_neg_from_mux_o});
    wr(ACR_OFS_CTL_B, 8'h00);
    // result presentation, done flag and interrupt
    wr(ACR_OFS_IRQ_MASK, 8'h01);
    done(10'h2B5);
    wait_n(3);
    chk("irq on", 8'h01, {7'h0, irq_o});
    rd_chk(ACR_OFS_IRQ_STAT, 8'h07, 8'h01, "irq stat");
    wait_n(2);
    chk("irq clr", 8'h00, {7'h0, irq_o});
    rd_chk(ACR_OFS_CTL_A, 8'h10, 8'h10, "done set");
    wr(ACR_OFS_CTL_A, 8'h90);
    rd_chk(ACR_OFS_CTL_A, 8'h10, 8'h00, "done clr");
    rd_chk(ACR_OFS_RES_LO, 8'hFF, 8'hB5, "lo right");
    rd_chk(ACR_OFS_RES_HI, 8'hFF, 8'h02, "hi right");
    wr(ACR_OFS_MUX, 8'h20);
    rd_chk(ACR_OFS_RES_LO, 8'hFF, 8'h40, "lo left");
    rd_chk(ACR_OFS_RES_HI, 8'hFF, 8'hAD, "hi left");
    wr(ACR_OFS_IRQ_MASK, 8'h00);
    wr(ACR_OFS_MUX, 8'h00);
    // masked event; a low read locks the result until the high read
    rd_chk(ACR_OFS_RES_LO, 8'hFF, 8'hB5, "lo lock");
    done(10'h1C3);
    wait_n(3);
    chk("irq masked", 8'h00, {7'h0, irq_o});
    rd_chk(ACR_OFS_RES_HI, 8'hFF, 8'h02, "hi locked");
    done(10'h1C3);
    rd_chk(ACR_OFS_RES_LO, 8'hFF, 8'hC3, "lo new");
    rd_chk(ACR_OFS_RES_HI, 8'hFF, 8'h01, "hi new");
    rd_chk(ACR_OFS_IRQ_STAT, 8'h01, 8'h01, "stat masked");
    // auto trigger off: flags have no effect
    wr(ACR_OFS_CTL_B, 8'h03);
    exp_start = n_start;
    trig_flags_i <= 8'h08;
    wait_n(3);
    chk("no auto", exp_start, n_start);
    @(posedge clk_sys_i);
    trig_flags_i <= 8'h00;
    // every flag source code, 1 to 7, starts only on its own flag edge
    wr(ACR_OFS_CTL_A, 8'hA0);
    for (int c = 1; c < 8; c++)
    begin
      wr(ACR_OFS_CTL_B, 8'(c));
      @(posedge clk_sys_i);
      trig_flags_i <= ~(8'h01 << c) & 8'hFE;
      wait_n(3);
      chk("other src", exp_start, n_start);
      @(posedge clk_sys_i);
      trig_flags_i <= 8'hFE;
      wait_n(3);
      exp_start = exp_start + 8'h01;
      chk("own src", exp_start, n_start);
      done(10'h000);
      @(posedge clk_sys_i);
      trig_flags_i <= 8'h00;
      wait_n(2);
    end
    // switching to a source whose flag is set makes an edge
    wr(ACR_OFS_CTL_B, 8'h01);
    @(posedge clk_sys_i);
    trig_flags_i <= 8'h20;
    wait_n(3);
    chk("sel clear", exp_start, n_start);
    wr(ACR_OFS_CTL_B, 8'h05);
    wait_n(3);
    exp_start = exp_start + 8'h01;
    chk("sel switch", exp_start, n_start);
    done(10'h000);
    trig_flags_i <= 8'h00;
    // free running selection with the done flag set is no event
    wr(ACR_OFS_CTL_B, 8'h00);
    wait_n(4);
    chk("free sel", exp_start, n_start);
    // free running: a completion restarts, and the converter reads busy
    done(10'h000);
    wait_n(2);
    exp_start = exp_start + 8'h01;
    chk("free restart", exp_start, n_start);
    rd_chk(ACR_OFS_CTL_A, 8'h40, 8'h40, "busy");
    // software start once idle, auto trigger off
    wr(ACR_OFS_CTL_A, 8'h80);
    done(10'h000);
    wr(ACR_OFS_CTL_A, 8'hC0);
    wait_n(2);
    exp_start = exp_start + 8'h01;
    chk("sw start", exp_start, n_start);
    end_of_test;
  end

endmodule // test_acr_adc_ctrl
